// >>> inc/regdrv_cfg.svh
// Constants for the registered address driver
`ifndef REGDRV_CFG_SVH
`define REGDRV_CFG_SVH

// ==========================================================
// Widths and depths
`define RD_WIDTH 14
`define RD_SYNC_STAGES 2
`define RD_RST_STAGES 2

// ==========================================================
// Reset values
`define RD_BIT_RESET 1'b0
`define RD_SKEW_RESET 1'b0
`define RD_RST_PIPE_RESET 2'h0

// ==========================================================
// Timing
`define RD_CLK_PERIOD_NS 100
`define RD_CAPTURE_LATENCY 3

`endif

// >>> inc/regdrv_pkg.sv
// Types shared by the registered address driver
package regdrv_pkg;

  // ==========================================================
  // Classification of one sample of the differential clock pair
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_CAPTURE,
    EDGE_SKEW
  } edge_kind_t;

  // ==========================================================
  // Life cycle of the driver after reset
  typedef enum logic [1:0] {
    LC_RESET,
    LC_WAIT_EDGE,
    LC_RUN
  } lifecycle_t;

endpackage

// >>> inc/capture_if.sv
// Carrier between capture control and the storage bank
`timescale 1ns/10ps

interface capture_if #(
  parameter int WIDTH = 14
);
  logic capture;
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] held;

  modport ctrl (
    output capture,
    output sample,
    input held
  );

  modport bank (
    input capture,
    input sample,
    output held
  );
endinterface

// >>> rtl/capture_bank.sv
// Bank of storage bits loaded on a capture strobe
`timescale 1ns/10ps
`include "regdrv_cfg.svh"

module capture_bank #(
  parameter int WIDTH = `RD_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  capture_if.bank cap
);

  // ==========================================================
  // Storage bits
  logic [WIDTH-1:0] held_ff;
  logic [WIDTH-1:0] nxt_held;

  always_comb begin
    nxt_held = held_ff;
    if (cap.capture) begin
      nxt_held = cap.sample;
    end
  end

  // Reset clears every bit at once, no clock needed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= {WIDTH{`RD_BIT_RESET}};
    end else begin
      held_ff <= nxt_held;
    end
  end

  assign cap.held = held_ff;

endmodule

// >>> rtl/registered_address_driver_14bit.sv
// Registered address driver: pair clock capture, reset, storage bank
`timescale 1ns/10ps
`include "regdrv_cfg.svh"

module registered_address_driver_14bit #(
  parameter int WIDTH = `RD_WIDTH,
  parameter int SYNC_STAGES = `RD_SYNC_STAGES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_true,
  input wire logic clk_comp,
  input wire logic [WIDTH-1:0] data_in_lines,
  output logic [WIDTH-1:0] registered_out_lines,
  output logic clock_pair_skew,
  output logic clock_seen
);

  // ==========================================================
  // Elaboration checks
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  localparam int PW = WIDTH + 2;

  // ==========================================================
  // Reset release
  // Assertion is immediate; release waits two clocks to avoid metastability
  logic [`RD_RST_STAGES-1:0] rst_pipe_ff;
  logic [`RD_RST_STAGES-1:0] nxt_rst_pipe;
  logic rst_n;

  always_comb begin
    nxt_rst_pipe = {rst_pipe_ff[`RD_RST_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_ff <= `RD_RST_PIPE_RESET;
    end else begin
      rst_pipe_ff <= nxt_rst_pipe;
    end
  end

  assign rst_n = rst_pipe_ff[`RD_RST_STAGES-1];

  // ==========================================================
  // Pin synchronisers
  // Clock pair and data share one pipeline so the sample stays aligned
  // with the edge that selects it
  logic [PW-1:0] sync_ff [SYNC_STAGES];
  logic [PW-1:0] nxt_sync [SYNC_STAGES];
  logic [1:0] pair_prev_ff;
  logic [1:0] nxt_pair_prev;
  logic [PW-1:0] pins_now;

  always_comb begin
    nxt_sync[0] = {clk_true, clk_comp, data_in_lines};
    for (int i = 1; i < SYNC_STAGES; i++) begin
      nxt_sync[i] = sync_ff[i-1];
    end
    nxt_pair_prev = sync_ff[SYNC_STAGES-1][PW-1:PW-2];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_ff[i] <= '0;
      end
      pair_prev_ff <= 2'h0;
    end else begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_ff[i] <= nxt_sync[i];
      end
      pair_prev_ff <= nxt_pair_prev;
    end
  end

  assign pins_now = sync_ff[SYNC_STAGES-1];

  // ==========================================================
  // Clock pair classification
  function automatic regdrv_pkg::edge_kind_t classify(
    input logic [1:0] prev,
    input logic [1:0] cur
  );
    logic t_rise;
    logic c_fall;
    t_rise = !prev[1] && cur[1];
    c_fall = prev[0] && !cur[0];
    if (t_rise && c_fall) begin
      classify = regdrv_pkg::EDGE_CAPTURE;
    end else if (t_rise || c_fall) begin
      classify = regdrv_pkg::EDGE_SKEW;
    end else begin
      classify = regdrv_pkg::EDGE_NONE;
    end
  endfunction

  regdrv_pkg::edge_kind_t edge_kind;
  assign edge_kind = classify(pair_prev_ff, pins_now[PW-1:PW-2]);

  // ==========================================================
  // Capture control
  // A lone transition on one line of the pair is not an edge and the outputs
  // hold; only a lone true rise or complement fall is flagged
  capture_if #(.WIDTH(WIDTH)) cap ();

  assign cap.capture = (edge_kind == regdrv_pkg::EDGE_CAPTURE);
  assign cap.sample = pins_now[WIDTH-1:0];

  logic skew_ff;
  logic nxt_skew;
  regdrv_pkg::lifecycle_t lc_ff;
  regdrv_pkg::lifecycle_t nxt_lc;
  // Registered copy so the status output comes straight from a flop
  logic seen_ff;
  logic nxt_seen;

  always_comb begin
    nxt_skew = (edge_kind == regdrv_pkg::EDGE_SKEW);
    nxt_lc = lc_ff;
    case (lc_ff)
      regdrv_pkg::LC_RESET: begin
        nxt_lc = regdrv_pkg::LC_WAIT_EDGE;
      end
      regdrv_pkg::LC_WAIT_EDGE: begin
        if (cap.capture) begin
          nxt_lc = regdrv_pkg::LC_RUN;
        end
      end
      regdrv_pkg::LC_RUN: begin
        nxt_lc = regdrv_pkg::LC_RUN;
      end
      default: begin
        nxt_lc = regdrv_pkg::LC_RESET;
      end
    endcase
    nxt_seen = (nxt_lc == regdrv_pkg::LC_RUN);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      skew_ff <= `RD_SKEW_RESET;
      lc_ff <= regdrv_pkg::LC_RESET;
      seen_ff <= 1'h0;
    end else begin
      skew_ff <= nxt_skew;
      lc_ff <= nxt_lc;
      seen_ff <= nxt_seen;
    end
  end

  // ==========================================================
  // Storage bank
  capture_bank #(.WIDTH(WIDTH)) u_bank (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cap(cap.bank)
  );

  assign registered_out_lines = cap.held;
  assign clock_pair_skew = skew_ff;
  assign clock_seen = seen_ff;

  // ==========================================================
  // Assertions
  sequence s_true_rise;
    !pair_prev_ff[1] && pins_now[PW-1];
  endsequence

  sequence s_comp_fall;
    pair_prev_ff[0] && !pins_now[PW-2];
  endsequence

  sequence s_comp_no_fall;
    !(pair_prev_ff[0] && !pins_now[PW-2]);
  endsequence

  property p_load_on_edge;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_true_rise and s_comp_fall) |=>
        registered_out_lines == $past(pins_now[WIDTH-1:0]);
  endproperty

  a_load_on_edge: assert property (p_load_on_edge)
    else $error("Outputs did not take the sample at the capture edge");

  a_hold_between_edges: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      !cap.capture |=> $stable(registered_out_lines))
    else $error("Outputs changed without a capture edge");

  a_skew_no_capture: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (s_true_rise and s_comp_no_fall) |=> clock_pair_skew &&
        $stable(registered_out_lines))
    else $error("Lone true-line rise was taken as an edge");

  a_reset_clears: assert property (
    @(posedge sys_clk)
      !rst_b |-> registered_out_lines == '0 && !clock_seen)
    else $error("Reset did not clear the storage bits");

  a_low_after_release: assert property (
    @(posedge sys_clk)
      $rose(rst_n) |-> registered_out_lines == '0 ##1
        (registered_out_lines == '0) [*2])
    else $error("Outputs not low through reset release");

endmodule

// >>> bench/ctrl_model.sv
// Partner model: controller driving the clock pair and address lines
`timescale 1ns/10ps

module ctrl_model (
  input wire logic sys_clk,
  output logic clk_true,
  output logic clk_comp,
  output logic [13:0] data_in_lines
);
  // ==========================================================
  // Idle pair; every line driven from time zero, none left floating
  initial begin
    clk_true = 1'b0;
    clk_comp = 1'b1;
    data_in_lines = 14'h0000;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ==========================================================
  // Opposite-phase pair edge; data held two periods either side
  task automatic capture(input logic [13:0] d);
    data_in_lines <= d;
    step(2);
    clk_true <= 1'b1;
    clk_comp <= 1'b0;
    step(2);
    // Data moves with the return of the pair, which must not capture
    data_in_lines <= ~d;
    clk_true <= 1'b0;
    clk_comp <= 1'b1;
    step(2);
  endtask

  // Only the true line of the pair moves, up and then down again; data goes to all ones
  task automatic lone_true();
    clk_true <= 1'b1;
    data_in_lines <= 14'h3fff;
    step(3);
    clk_true <= 1'b0;
    step(3);
  endtask
endmodule

// >>> bench/registered_address_driver_14bit_test.sv
// Self-checking testbench of the registered address driver
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("MISMATCH t=%0t %s", $time, msg); end end

module registered_address_driver_14bit_test;
  logic sys_clk;
  logic rst_b;
  logic clk_true;
  logic clk_comp;
  logic [13:0] data_in_lines;
  logic [13:0] registered_out_lines;
  logic clock_pair_skew;
  logic clock_seen;
  int mismatches = 0;
  int total_checks = 0;
  int skews = 0;

  ctrl_model ctrl_model_i (
    .sys_clk(sys_clk),
    .clk_true(clk_true),
    .clk_comp(clk_comp),
    .data_in_lines(data_in_lines)
  );

  registered_address_driver_14bit registered_address_driver_14bit_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_true(clk_true),
    .clk_comp(clk_comp),
    .data_in_lines(data_in_lines),
    .registered_out_lines(registered_out_lines),
    .clock_pair_skew(clock_pair_skew),
    .clock_seen(clock_seen)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Counted on the falling edge, away from the flops' own update
  always @(negedge sys_clk) begin
    if (clock_pair_skew === 1'b1) skews++;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset_hold();
    `CHECK(registered_out_lines, 14'h0000, "outputs not low in reset")
    `CHECK(clock_seen, 1'b0, "seen flag set in reset")
  endtask

  task automatic test_capture(input logic [13:0] d);
    ctrl_model_i.capture(d);
    #10;
    `CHECK(registered_out_lines, d, "wrong captured value")
    `CHECK(clock_seen, 1'b1, "seen flag not set")
    @(posedge sys_clk);
  endtask

  task automatic test_lone(input logic [13:0] exp);
    skews = 0;
    ctrl_model_i.lone_true();
    #10;
    // Only the lone rise is flagged; the lone fall back to idle is not
    `CHECK(skews, 1, "skew pulses not one")
    `CHECK(registered_out_lines, exp, "lone line changed outputs")
    @(posedge sys_clk);
  endtask

  task automatic test_mid_reset();
    rst_b <= 1'b0;
    #1;
    `CHECK(registered_out_lines, 14'h0000, "reset not immediate")
    @(posedge sys_clk);
    // A full capture while reset is held must leave the outputs low
    ctrl_model_i.capture(14'h1234);
    #10;
    `CHECK(registered_out_lines, 14'h0000, "outputs moved in reset")
    `CHECK(clock_seen, 1'b0, "seen flag moved in reset")
    @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    // A real falling edge on the pin, so the flops clear before the first clock
    rst_b = 1'b1;
    #1;
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    #10;
    test_reset_hold();
    @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    test_capture(14'h2a55);
    test_capture(14'h15aa);
    test_lone(14'h15aa);
    test_mid_reset();
    test_capture(14'h3fff);
    complete_run();
  end

  // Whole run is well under a hundred cycles; allow twenty times that
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule
